// File: dv/dccfb_top_sva.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker; reads are judged on any ready cycle without an error
module dccfb_top_sva (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire dccfb_pkg::dccfb_hs_sel_t hs_reg_sel_o,
   input wire logic [7:0] hs_block_disable_n_o,
   input wire logic [15:0] mbx_hs_onehot_o [8],
   input wire dccfb_pkg::dccfb_owner_t owner_o,
   input wire logic secondary_two_speed_startup_o,
   input wire dccfb_pkg::dccfb_osc_t secondary_osc_source_sel_o,
   input wire logic osc_sel_reserved_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   wire rd_ok = pready_o && !pwrite_i && !pslverr_o;
   wire [76:0] fuse_vec = {owner_o, hs_block_disable_n_o};
   ready_one_cycle_a: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   err_with_ready_a: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   ready_in_access_a: assert property (pready_o |-> psel_i && penable_i)
      else $error("ready outside access");
   fuse_rd_lat_a: assert property (psel_i && !penable_i && !pwrite_i &&
      !pready_o && paddr_i <= 8'h24 && paddr_i[1:0] == 2'b00
      |=> !pready_o ##1 pready_o) else $error("fuse read latency");
   unmapped_err_a: assert property (pready_o && paddr_i > 8'h2c
      |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped access");
   assign_pad_a: assert property (rd_ok && paddr_i == 8'h04
      |-> prdata_o[23:16] == 8'hff) else $error("assign pad bits");
   enable_rd_a: assert property (rd_ok && paddr_i == 8'h08
      |-> prdata_o[7:0] == hs_block_disable_n_o
      && prdata_o[23:8] == 16'hffff) else $error("enable word read");
   osc_rd_a: assert property (rd_ok && paddr_i == 8'h20
      |-> prdata_o[7] == secondary_two_speed_startup_o
      && prdata_o[2:0] == secondary_osc_source_sel_o)
      else $error("osc word read");
   rsvd_flag_a: assert property ($stable(secondary_osc_source_sel_o)
      |-> osc_sel_reserved_o == (secondary_osc_source_sel_o == 3'b100))
      else $error("reserved flag");
   onehot_h_a: assert property ($stable(hs_reg_sel_o.h)
      |-> mbx_hs_onehot_o[7] == 16'h1 << hs_reg_sel_o.h)
      else $error("block h decode");
   clear_only_a: assert property (
      (fuse_vec & ~$past(fuse_vec)) == 77'h0) else $error("fuse bit set");
   cover property (pslverr_o);
   cover property (osc_sel_reserved_o);
   cover property (rd_ok && paddr_i == 8'h04);
endmodule : dccfb_top_sva

bind dccfb_top dccfb_top_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .hs_reg_sel_o(hs_reg_sel_o),
   .hs_block_disable_n_o(hs_block_disable_n_o),
   .mbx_hs_onehot_o(mbx_hs_onehot_o), .owner_o(owner_o),
   .secondary_two_speed_startup_o(secondary_two_speed_startup_o),
   .secondary_osc_source_sel_o(secondary_osc_source_sel_o),
   .osc_sel_reserved_o(osc_sel_reserved_o));

// File: dv/dccfb_top_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Fuse bank bench over APB
module dccfb_top_tb;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   dccfb_pkg::dccfb_hs_sel_t hs_reg_sel_o;
   logic [7:0] hs_block_disable_n_o;
   logic [15:0] mbx_hs_onehot_o [8];
   dccfb_pkg::dccfb_owner_t owner_o;
   logic secondary_two_speed_startup_o;
   dccfb_pkg::dccfb_osc_t secondary_osc_source_sel_o;
   logic osc_sel_reserved_o;
   logic [15:0] mailbox_direction_sel_o;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic [31:0] pd [5] = '{32'h0a, 32'h1234, 32'h8001, 32'h00ff, 32'hfe7f};
   logic er;

   dccfb_top DUT (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .hs_reg_sel_o, .hs_block_disable_n_o, .mbx_hs_onehot_o, .owner_o,
      .secondary_two_speed_startup_o, .secondary_osc_source_sel_o,
      .osc_sel_reserved_o, .mailbox_direction_sel_o);

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   // Hang guard; the whole run needs only a few hundred cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end

   task conclude;
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   task cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp

   // Request held until pready is seen at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(rd, e);
   endtask : rdc

   task prog(input logic [3:0] idx, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      apb(1'b1, a, d);
      apb(1'b1, dccfb_pkg::ADDR_PROG_CTRL,
         {dccfb_pkg::PROG_KEY, 4'h0, idx, 8'h01});
      cmp(er, 32'h0);
      do begin
         apb(1'b0, dccfb_pkg::ADDR_PROG_STAT, 32'h0);
         n++;
      end while (rd[0] === 1'b1 && n < 20);
      cmp(rd, 32'h0);
      // Outputs follow the burn within two cycles
      repeat (3) @(posedge clk_i);
   endtask : prog

   initial begin
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 10; i++) rdc(8'(i * 4), 32'h00ffffff);
      cmp(hs_reg_sel_o, 32'hffffffff);
      cmp(hs_block_disable_n_o, 32'hff);
      prog(4'h1, 8'h04, 32'h3c59);
      rdc(8'h04, 32'h00ff3c59);
      cmp(hs_reg_sel_o[31:16], 32'h3c59);
      cmp(mbx_hs_onehot_o[7], 32'h0008);
      cmp(mbx_hs_onehot_o[4], 32'h0200);
      prog(4'h1, 8'h04, 32'hffffff);
      rdc(8'h04, 32'h00ff3c59);
      prog(4'h0, 8'h00, 32'hf0e1);
      rdc(8'h00, 32'h00fff0e1);
      cmp(hs_reg_sel_o[15:0], 32'hf0e1);
      cmp(mbx_hs_onehot_o[3], 32'h8000);
      cmp(mbx_hs_onehot_o[2], 32'h0001);
      prog(4'h2, 8'h08, 32'h5a);
      rdc(8'h08, 32'h00ffff5a);
      cmp(hs_block_disable_n_o, 32'h5a);
      for (int i = 0; i < 5; i++) begin
         prog(4'(i + 3), 8'(12 + i * 4), pd[i]);
         rdc(8'(12 + i * 4), {8'h0, 24'hffffff & (pd[i] |
            ~(i == 0 ? 24'h1f : 24'hffff))});
      end
      cmp(owner_o.a, pd[0]);
      cmp(owner_o.b, pd[1]);
      cmp(owner_o.c, pd[2]);
      cmp(owner_o.d, pd[3]);
      cmp(owner_o.e, pd[4]);
      prog(4'h9, 8'h24, 32'h00f0);
      cmp(mailbox_direction_sel_o, 32'h00f0);
      apb(1'b0, 8'h40, 32'h0);
      cmp({er, rd[30:0]}, 32'h80000000);
      apb(1'b1, 8'h28, 32'h12340301);
      cmp(er, 32'h1);
      apb(1'b1, 8'h28, {dccfb_pkg::PROG_KEY, 16'h0a01});
      cmp(er, 32'h1);
      rdc(8'h2c, 32'h00000002);
      apb(1'b1, 8'h0c, 32'h0);
      rdc(8'h0c, 32'h00ffffea);
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_i);
         rstn_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         rstn_i <= 1'b1;
         prog(4'h8, 8'h20, {24'h0, c[0], 4'h0, 3'(c)});
         rdc(8'h20, {24'h00ffff, c[0], 4'hf, 3'(c)});
         cmp(secondary_osc_source_sel_o, 32'(c));
         cmp(secondary_two_speed_startup_o, 32'(c % 2));
         cmp(osc_sel_reserved_o, 32'(c == 4));
      end
      conclude();
   end
endmodule : dccfb_top_tb

// File: pkg/dccfb_pkg.sv
package dccfb_pkg;

   // ==========================================================
   // Register map (byte addresses, one word each)
   localparam logic [7:0] ADDR_HS_ASSIGN_LOWER = 8'h00;
   localparam logic [7:0] ADDR_HS_ASSIGN_UPPER = 8'h04;
   localparam logic [7:0] ADDR_HS_ENABLE = 8'h08;
   localparam logic [7:0] ADDR_PORT_A = 8'h0c;
   localparam logic [7:0] ADDR_PORT_B = 8'h10;
   localparam logic [7:0] ADDR_PORT_C = 8'h14;
   localparam logic [7:0] ADDR_PORT_D = 8'h18;
   localparam logic [7:0] ADDR_PORT_E = 8'h1c;
   localparam logic [7:0] ADDR_OSC_SEL = 8'h20;
   localparam logic [7:0] ADDR_MBX_DIR = 8'h24;
   localparam logic [7:0] ADDR_PROG_CTRL = 8'h28;
   localparam logic [7:0] ADDR_PROG_STAT = 8'h2c;

   // ==========================================================
   // Fuse word geometry
   localparam int WORD_W = 24;
   localparam int NUM_WORDS = 10;
   localparam int IDX_W = 4;
   localparam logic [3:0] IDX_HS_LOWER = 4'h0;
   localparam logic [3:0] IDX_HS_UPPER = 4'h1;
   localparam logic [3:0] IDX_HS_EN = 4'h2;
   localparam logic [3:0] IDX_PORT_A = 4'h3;
   localparam logic [3:0] IDX_PORT_B = 4'h4;
   localparam logic [3:0] IDX_PORT_C = 4'h5;
   localparam logic [3:0] IDX_PORT_D = 4'h6;
   localparam logic [3:0] IDX_PORT_E = 4'h7;
   localparam logic [3:0] IDX_OSC = 4'h8;
   localparam logic [3:0] IDX_MBX_DIR = 4'h9;

   // Implemented-bit masks per word; other bits read as one
   localparam logic [23:0] MASK_HS_ASSIGN = 24'h00ffff;
   localparam logic [23:0] MASK_HS_EN = 24'h0000ff;
   localparam logic [23:0] MASK_PORT_A = 24'h00001f;
   localparam logic [23:0] MASK_PORT_16 = 24'h00ffff;
   localparam logic [23:0] MASK_OSC = 24'h000087;
   localparam logic [23:0] MASK_MBX_DIR = 24'h00ffff;
   localparam logic [23:0] FUSE_ERASED = 24'hffffff;

   // ==========================================================
   // Field positions
   localparam int HS_SEL_W = 4;
   localparam int HS_H_LSB = 12;
   localparam int HS_G_LSB = 8;
   localparam int HS_F_LSB = 4;
   localparam int HS_E_LSB = 0;
   localparam int OSC_IESO_BIT = 7;
   localparam int OSC_SRC_LSB = 0;

   // Programming control: key in upper half, word index, go bit
   localparam logic [15:0] PROG_KEY = 16'h5a3c;
   localparam int PROG_KEY_LSB = 16;
   localparam int PROG_IDX_LSB = 8;
   localparam int PROG_GO_BIT = 0;

   typedef enum logic [2:0] {
      OSC_FRC = 3'b000,
      OSC_FRC_PLL = 3'b001,
      OSC_PRI = 3'b010,
      OSC_PRI_PLL = 3'b011,
      OSC_RSVD = 3'b100,
      OSC_LOW_POWER_RC_OSC = 3'b101,
      OSC_BACKUP_FAST_RC_OSC = 3'b110,
      OSC_FRC_DIV = 3'b111
   } dccfb_osc_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_PROG = 2'b10
   } dccfb_state_t;

   typedef struct packed {
      logic [3:0] h;
      logic [3:0] g;
      logic [3:0] f;
      logic [3:0] e;
      logic [3:0] d;
      logic [3:0] c;
      logic [3:0] b;
      logic [3:0] a;
   } dccfb_hs_sel_t;

   typedef struct packed {
      logic [4:0] a;
      logic [15:0] b;
      logic [15:0] c;
      logic [15:0] d;
      logic [15:0] e;
   } dccfb_owner_t;

endpackage : dccfb_pkg

// File: rtl/dccfb_fuse_mem.sv
`timescale 1ns/1ps
// ==========================================================
// Fuse array: erased to ones, write may only clear bits
module dccfb_fuse_mem (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic wr_i,
   input wire logic [3:0] wr_idx_i,
   input wire logic [23:0] wr_data_i,
   input wire logic [3:0] rd_idx_i,
   output logic [23:0] rd_data_o
);
   logic [23:0] mem_q [dccfb_pkg::NUM_WORDS];

   // Power-on value is all ones, programming only burns ones to zero
   for (genvar i = 0; i < dccfb_pkg::NUM_WORDS; i++) begin : g_word
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            mem_q[i] <= dccfb_pkg::FUSE_ERASED;
         end else if (wr_i && wr_idx_i == 4'(i)) begin
            mem_q[i] <= mem_q[i] & wr_data_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_o <= dccfb_pkg::FUSE_ERASED;
      end else if (rd_idx_i < 4'(dccfb_pkg::NUM_WORDS)) begin
         rd_data_o <= mem_q[rd_idx_i];
      end else begin
         rd_data_o <= dccfb_pkg::FUSE_ERASED;
      end
   end
endmodule : dccfb_fuse_mem

// File: rtl/dccfb_top.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Functional notes
// - Upper assign word: block H select bits 15-12, block G bits 11-8.
// - Upper assign word: block F select bits 7-4, block E bits 3-0.
// - Select code n picks mailbox data register n, 0 to 15.
// - Enable fuse bit 1 disables a handshake block, 0 enables it.
// - Enable word bits 7-0 are blocks H down to A.
// - Port A ownership word: five pin bits at 4-0.
// - Ownership bit 1 gives pin to primary core, 0 to secondary.
// - Oscillator word bit 7 set enables switchover and two-speed start.
// - Source 111 divided fast RC, 110 backup, 101 low-power, 100 reserved.
// - Source 011 primary with PLL, 010 primary, 001 RC PLL, 000 RC.
// - Unimplemented bits read as one, e.g. assign word bits 23-16.
// - Each bit programs once, reads back; one at reset until programmed; here every reset sets all bits back to one.
// - Lower assign word holds blocks A to D selects, same encoding.
// - Mailbox direction bit 1 secondary-to-primary, 0 primary-to-secondary.
module dccfb_top (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output dccfb_pkg::dccfb_hs_sel_t hs_reg_sel_o,
   output logic [7:0] hs_block_disable_n_o,
   output logic [15:0] mbx_hs_onehot_o [8],
   output dccfb_pkg::dccfb_owner_t owner_o,
   output logic secondary_two_speed_startup_o,
   output dccfb_pkg::dccfb_osc_t secondary_osc_source_sel_o,
   output logic osc_sel_reserved_o,
   output logic [15:0] mailbox_direction_sel_o
);

   // ==========================================================
   // State
   // Fuse contents return to erased at every reset; nothing is kept
   typedef struct packed {
      dccfb_pkg::dccfb_state_t st;
      logic [3:0] idx;
      logic [23:0] wdata;
      logic busy;
      logic err;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic wr;
      logic [3:0] rd_idx;
      logic [9:0][23:0] shadow;
   } dccfb_regs_t;

   dccfb_regs_t s_q;
   dccfb_regs_t s_d;
   logic [23:0] mem_rd;
   logic [23:0] mask [10];
   logic [23:0] raw;

   // ==========================================================
   // Fuse word masks
   // Unimplemented bits are forced to one on read and on burn
   assign mask[0] = dccfb_pkg::MASK_HS_ASSIGN;
   assign mask[1] = dccfb_pkg::MASK_HS_ASSIGN;
   assign mask[2] = dccfb_pkg::MASK_HS_EN;
   assign mask[3] = dccfb_pkg::MASK_PORT_A;
   assign mask[4] = dccfb_pkg::MASK_PORT_16;
   assign mask[5] = dccfb_pkg::MASK_PORT_16;
   assign mask[6] = dccfb_pkg::MASK_PORT_16;
   assign mask[7] = dccfb_pkg::MASK_PORT_16;
   assign mask[8] = dccfb_pkg::MASK_OSC;
   assign mask[9] = dccfb_pkg::MASK_MBX_DIR;
   assign raw = mem_rd | ~mask[s_q.rd_idx];

   // ==========================================================
   // Fuse array
   // Index from the next state, so a read word is out by the access cycle
   dccfb_fuse_mem u_mem (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .wr_i(s_q.wr),
      .wr_idx_i(s_q.idx),
      .wr_data_i(s_q.wdata),
      .rd_idx_i(s_d.rd_idx),
      .rd_data_o(mem_rd)
   );

   // ==========================================================
   // Next state
   logic [3:0] aidx;
   logic amap;
   logic setup;
   logic [3:0] pidx;
   always_comb begin
      s_d = s_q;
      s_d.ready = 1'b0;
      s_d.slverr = 1'b0;
      s_d.wr = 1'b0;
      setup = psel_i && !penable_i && !s_q.ready;
      pidx = pwdata_i[dccfb_pkg::PROG_IDX_LSB +: 4];
      // Address decode; amap low means no fuse word sits at this address
      amap = 1'b1;
      aidx = 4'h0;
      if (paddr_i == dccfb_pkg::ADDR_HS_ASSIGN_LOWER) begin
         aidx = dccfb_pkg::IDX_HS_LOWER;
      end else if (paddr_i == dccfb_pkg::ADDR_HS_ASSIGN_UPPER) begin
         aidx = dccfb_pkg::IDX_HS_UPPER;
      end else if (paddr_i == dccfb_pkg::ADDR_HS_ENABLE) begin
         aidx = dccfb_pkg::IDX_HS_EN;
      end else if (paddr_i == dccfb_pkg::ADDR_PORT_A) begin
         aidx = dccfb_pkg::IDX_PORT_A;
      end else if (paddr_i == dccfb_pkg::ADDR_PORT_B) begin
         aidx = dccfb_pkg::IDX_PORT_B;
      end else if (paddr_i == dccfb_pkg::ADDR_PORT_C) begin
         aidx = dccfb_pkg::IDX_PORT_C;
      end else if (paddr_i == dccfb_pkg::ADDR_PORT_D) begin
         aidx = dccfb_pkg::IDX_PORT_D;
      end else if (paddr_i == dccfb_pkg::ADDR_PORT_E) begin
         aidx = dccfb_pkg::IDX_PORT_E;
      end else if (paddr_i == dccfb_pkg::ADDR_OSC_SEL) begin
         aidx = dccfb_pkg::IDX_OSC;
      end else if (paddr_i == dccfb_pkg::ADDR_MBX_DIR) begin
         aidx = dccfb_pkg::IDX_MBX_DIR;
      end else begin
         amap = 1'b0;
      end
      // Bus sequencing: one setup is handled per idle cycle
      case (s_q.st)
         dccfb_pkg::ST_IDLE: begin
            // Only an idle cycle takes a setup; the answer follows it
            if (setup) begin
               s_d.rd_idx = aidx;
               if (pwrite_i && paddr_i == dccfb_pkg::ADDR_PROG_CTRL) begin
                  // Program request: key, valid index, go bit
                  if (pwdata_i[dccfb_pkg::PROG_GO_BIT] &&
                      pwdata_i[31:dccfb_pkg::PROG_KEY_LSB] ==
                      dccfb_pkg::PROG_KEY &&
                      pidx < 4'(dccfb_pkg::NUM_WORDS) && !s_q.busy) begin
                     s_d.idx = pidx;
                     s_d.busy = 1'b1;
                     s_d.err = 1'b0;
                     s_d.st = dccfb_pkg::ST_PROG;
                  end else begin
                     // Refused: error flag stays until an accepted request
                     s_d.err = 1'b1;
                     s_d.slverr = 1'b1;
                  end
                  s_d.ready = 1'b1;
               end else if (pwrite_i && amap) begin
                  // Data word staged; burned by the next program request
                  s_d.wdata = pwdata_i[23:0];
                  s_d.ready = 1'b1;
               end else if (!pwrite_i && amap) begin
                  s_d.st = dccfb_pkg::ST_LOAD;
               end else if (!pwrite_i &&
                            paddr_i == dccfb_pkg::ADDR_PROG_STAT) begin
                  // Status: busy in bit 0, error in bit 1
                  s_d.rdata = {30'h0, s_q.err, s_q.busy};
                  s_d.ready = 1'b1;
               end else begin
                  s_d.slverr = 1'b1;
                  s_d.rdata = 32'h0;
                  s_d.ready = 1'b1;
               end
            end
         end
         dccfb_pkg::ST_LOAD: begin
            // Read data comes from the memory's output register
            s_d.rdata = {8'h0, raw};
            s_d.ready = 1'b1;
            s_d.st = dccfb_pkg::ST_IDLE;
         end
         dccfb_pkg::ST_PROG: begin
            // Unimplemented bits stay one: data masked before burning
            // One-cycle burn; busy drops as the write strobe rises
            s_d.wdata = s_q.wdata | ~mask[s_q.idx];
            s_d.wr = 1'b1;
            s_d.busy = 1'b0;
            s_d.rd_idx = s_q.idx;
            s_d.st = dccfb_pkg::ST_IDLE;
         end
         default: begin
            s_d.st = dccfb_pkg::ST_IDLE;
         end
      endcase
      // Shadow copies feed the static outputs; refreshed after a burn
      // The shadow mirrors the array so outputs need no read port
      for (int i = 0; i < dccfb_pkg::NUM_WORDS; i++) begin
         if (s_q.wr && s_q.idx == 4'(i)) begin
            s_d.shadow[i] = s_q.shadow[i] & s_q.wdata;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q.st <= dccfb_pkg::ST_IDLE;
         s_q.idx <= 4'h0;
         s_q.wdata <= dccfb_pkg::FUSE_ERASED;
         s_q.busy <= 1'b0;
         s_q.err <= 1'b0;
         s_q.rdata <= 32'h0;
         s_q.ready <= 1'b0;
         s_q.slverr <= 1'b0;
         s_q.wr <= 1'b0;
         s_q.rd_idx <= 4'h0;
         for (int i = 0; i < dccfb_pkg::NUM_WORDS; i++) begin
            s_q.shadow[i] <= dccfb_pkg::FUSE_ERASED;
         end
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Static configuration outputs
   // Plain taps of the shadow words; the output registers add one cycle
   logic [23:0] w_up;
   logic [23:0] w_lo;
   logic [23:0] w_osc;
   assign w_up = s_q.shadow[dccfb_pkg::IDX_HS_UPPER];
   assign w_lo = s_q.shadow[dccfb_pkg::IDX_HS_LOWER];
   assign w_osc = s_q.shadow[dccfb_pkg::IDX_OSC];

   // ==========================================================
   // Handshake register selects
   logic [3:0] sel_all [8];
   assign sel_all[7] = w_up[dccfb_pkg::HS_H_LSB +: 4];
   assign sel_all[6] = w_up[dccfb_pkg::HS_G_LSB +: 4];
   assign sel_all[5] = w_up[dccfb_pkg::HS_F_LSB +: 4];
   assign sel_all[4] = w_up[dccfb_pkg::HS_E_LSB +: 4];
   assign sel_all[3] = w_lo[dccfb_pkg::HS_H_LSB +: 4];
   assign sel_all[2] = w_lo[dccfb_pkg::HS_G_LSB +: 4];
   assign sel_all[1] = w_lo[dccfb_pkg::HS_F_LSB +: 4];
   assign sel_all[0] = w_lo[dccfb_pkg::HS_E_LSB +: 4];

   // ==========================================================
   // One-hot mailbox decode
   // Decoded once here so no handshake block needs its own comparator
   logic [15:0] onehot_q [8];
   logic [3:0] sel_q [8];
   for (genvar b = 0; b < 8; b++) begin : g_hs
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            sel_q[b] <= 4'hf;
            onehot_q[b] <= 16'h8000;
         end else begin
            sel_q[b] <= sel_all[b];
            onehot_q[b] <= 16'h0001 << sel_all[b];
         end
      end
      assign mbx_hs_onehot_o[b] = onehot_q[b];
   end

   // ==========================================================
   // Bus and configuration outputs
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prdata_o <= 32'h0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         hs_block_disable_n_o <= 8'hff;
         owner_o <= '1;
         secondary_two_speed_startup_o <= 1'b1;
         secondary_osc_source_sel_o <= dccfb_pkg::OSC_FRC_DIV;
         osc_sel_reserved_o <= 1'b0;
         mailbox_direction_sel_o <= 16'hffff;
      end else begin
         prdata_o <= s_d.rdata;
         pready_o <= s_d.ready;
         pslverr_o <= s_d.slverr;
         // Bit b high means block b held off
         hs_block_disable_n_o <=
            s_q.shadow[dccfb_pkg::IDX_HS_EN][7:0];
         owner_o.a <= s_q.shadow[dccfb_pkg::IDX_PORT_A][4:0];
         owner_o.b <= s_q.shadow[dccfb_pkg::IDX_PORT_B][15:0];
         owner_o.c <= s_q.shadow[dccfb_pkg::IDX_PORT_C][15:0];
         owner_o.d <= s_q.shadow[dccfb_pkg::IDX_PORT_D][15:0];
         owner_o.e <= s_q.shadow[dccfb_pkg::IDX_PORT_E][15:0];
         secondary_two_speed_startup_o <=
            w_osc[dccfb_pkg::OSC_IESO_BIT];
         // Reserved code passes through; the flag lets consumers refuse it
         secondary_osc_source_sel_o <=
            dccfb_pkg::dccfb_osc_t'(w_osc[2:0]);
         osc_sel_reserved_o <=
            (w_osc[2:0] == 3'(dccfb_pkg::OSC_RSVD));
         mailbox_direction_sel_o <=
            s_q.shadow[dccfb_pkg::IDX_MBX_DIR][15:0];
      end
   end

   // ==========================================================
   // Outputs hold still between burns; consumers need no handshake
   // Select outputs registered per block
   assign hs_reg_sel_o = {sel_q[7], sel_q[6], sel_q[5], sel_q[4],
                          sel_q[3], sel_q[2], sel_q[1], sel_q[0]};

endmodule : dccfb_top
